/* common/sgl_desc_map.svh */
// Purpose: Offsets, field positions and codes of a 16-byte list descriptor
// Assumes: Byte n of the descriptor sits in bits 8n+7 to 8n of a 128-bit word
// Notes:   Definitions only
`ifndef SGL_DESC_MAP_SVH
`define SGL_DESC_MAP_SVH

// Descriptor width
`define SGL_DESC_BITS       128

// Address field, bytes 7 to 0
`define SGL_ADDR_LSB        0
`define SGL_ADDR_MSB        63

// Length field, bytes 11 to 8
`define SGL_LEN_LSB         64
`define SGL_LEN_MSB         95

// Byte 15: zero nibble and type nibble
`define SGL_ZERO_LSB        120
`define SGL_ZERO_MSB        123
`define SGL_TYPE_LSB        124
`define SGL_TYPE_MSB        127

// Type codes
`define SGL_TYPE_DATA       4'h0
`define SGL_TYPE_BUCKET     4'h1
`define SGL_TYPE_SEGMENT    4'h2
`define SGL_TYPE_LAST       4'h3

// Zero field value
`define SGL_ZERO_VALUE      4'h0

// Segment length granule, as a shift
`define SGL_GRAIN_SHIFT     4

// Top of the 64-bit address space
`define SGL_ADDR_LIMIT      65'h1_0000_0000_0000_0000

`endif

/* common/sgl_desc_pkg.sv */
// Purpose: Types shared by the descriptor checker
// Assumes: Codes themselves live in the map header
// Notes:   No constants beyond enumerations
package sgl_desc_pkg;

    // Descriptor kinds
    typedef enum logic [3:0] {
        kind_data    = 4'h0,
        kind_bucket  = 4'h1,
        kind_segment = 4'h2,
        kind_last    = 4'h3
    } desc_kind_t;

    // Error codes
    typedef enum logic [2:0] {
        err_none     = 3'h0,
        err_type     = 3'h1,
        err_data_len = 3'h2,
        err_meta_len = 3'h3,
        err_nesting  = 3'h4
    } err_code_t;

    // Walker states, Gray along idle, walk, fetch, halt
    typedef enum logic [1:0] {
        st_idle  = 2'h0,
        st_walk  = 2'h1,
        st_fetch = 2'h3,
        st_halt  = 2'h2
    } walk_state_t;

endpackage

/* rtl/sgl_desc_fields.sv */
// Purpose: Field extraction and static checks of one descriptor
// Assumes: Raw word as laid out in the map header
// Notes:   Purely combinational
`timescale 1ns/100ps
`include "sgl_desc_map.svh"

module sgl_desc_fields (
    // Raw descriptor
    input  wire logic [127:0] raw,
    // Decoded fields
    output logic      [63:0]  addr,
    output logic      [31:0]  len,
    output logic      [3:0]   kind,
    // Checks
    output logic              zero_bad,
    output logic              kind_known,
    output logic              is_chain,
    output logic              len_bad,
    output logic              wraps
);

    logic [64:0] end_sum;

    // Bytes 14 to 12 are never looked at
    assign addr       = raw[`SGL_ADDR_MSB:`SGL_ADDR_LSB];
    assign len        = raw[`SGL_LEN_MSB:`SGL_LEN_LSB];
    assign kind       = raw[`SGL_TYPE_MSB:`SGL_TYPE_LSB];
    assign zero_bad   = raw[`SGL_ZERO_MSB:`SGL_ZERO_LSB] != `SGL_ZERO_VALUE;
    assign kind_known = (kind == `SGL_TYPE_DATA) || (kind == `SGL_TYPE_BUCKET)
                     || (kind == `SGL_TYPE_SEGMENT) || (kind == `SGL_TYPE_LAST);
    assign is_chain   = (kind == `SGL_TYPE_SEGMENT) || (kind == `SGL_TYPE_LAST);
    assign len_bad    = (len == 32'h0000_0000)
                     || (len[`SGL_GRAIN_SHIFT-1:0] != 4'h0);
    assign end_sum    = {1'b0, addr} + {33'h0_0000_0000, len};
    assign wraps      = end_sum > `SGL_ADDR_LIMIT;

endmodule

/* rtl/sgl_segment_descriptor_check.sv */
// Purpose: Walks list segments, checks chaining descriptors, issues fetches
// Assumes: Caller feeds every descriptor of the current segment in order
// Notes:   Data and bucket descriptors pass out unchecked beyond their type
//
// Function
// - Chaining descriptor bytes 7..0 give the next segment's 64-bit address.
// - Chaining descriptor bytes 11..8 give the next segment's byte length.
// - Chaining descriptor address plus length past 2^64 is a length error.
// - Final descriptor address plus length past 2^64 is a length error.
// - Nonzero low nibble of byte 15 is a descriptor type error.
// - Byte 15 high nibble: 2h chaining segment, 3h final segment.
// - Final descriptor marks the fetched segment last; no further chaining.
// - Final descriptor bytes 7..0 give the last segment's 64-bit address.
// - Final descriptor bytes 11..8 give the last segment's byte count.
// - A segment descriptor inside the last segment is an error.
// - A chaining segment is not last; it may hold further segment descriptors.
// - Type 0h is a data block, 1h a bit bucket.
`timescale 1ns/100ps
`include "sgl_desc_map.svh"

module sgl_segment_descriptor_check (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // List start
    input  wire logic         list_start,
    input  wire logic         list_meta,
    input  wire logic [31:0]  list_len,
    input  wire logic         list_last,
    // Descriptor stream
    input  wire logic         desc_valid,
    output logic              desc_ready,
    input  wire logic [127:0] desc_data,
    // Data and bucket items
    output logic              item_valid,
    input  wire logic         item_ready,
    output logic [3:0]        item_kind,
    output logic [63:0]       item_addr,
    output logic [31:0]       item_len,
    // Next segment fetch
    output logic              fetch_valid,
    input  wire logic         fetch_ready,
    output logic [63:0]       fetch_addr,
    output logic [31:0]       fetch_len,
    output logic              fetch_last,
    // Status
    output logic              err_valid,
    output logic [2:0]        err_code,
    output logic              list_done,
    output logic              busy
);

    sgl_desc_pkg::walk_state_t state;
    sgl_desc_pkg::walk_state_t next_state;

    logic [27:0] remain;
    logic [27:0] next_remain;
    logic        seg_last;
    logic        next_seg_last;
    logic        meta;
    logic        next_meta;

    logic [63:0] f_addr;
    logic [31:0] f_len;
    logic [3:0]  f_kind;
    logic        f_zero_bad;
    logic        f_kind_known;
    logic        f_is_chain;
    logic        f_len_bad;
    logic        f_wraps;

    // Field decoder
    sgl_desc_fields u_fields (
        .raw        (desc_data),
        .addr       (f_addr),
        .len        (f_len),
        .kind       (f_kind),
        .zero_bad   (f_zero_bad),
        .kind_known (f_kind_known),
        .is_chain   (f_is_chain),
        .len_bad    (f_len_bad),
        .wraps      (f_wraps)
    );

    // Handshake and decode wires
    wire in_walk     = state == sgl_desc_pkg::st_walk;
    wire in_fetch    = state == sgl_desc_pkg::st_fetch;
    wire can_start   = (state == sgl_desc_pkg::st_idle) || (state == sgl_desc_pkg::st_halt);
    wire take_start  = list_start && can_start;
    wire start_bad   = (list_len == 32'h0000_0000)
                    || (list_len[`SGL_GRAIN_SHIFT-1:0] != 4'h0);
    wire take_desc   = desc_valid && desc_ready;
    wire fetch_take  = fetch_valid && fetch_ready;
    wire item_take   = item_valid && item_ready;
    wire bad_type    = f_zero_bad || !f_kind_known;
    wire bad_nest    = f_is_chain && seg_last;
    wire bad_len     = f_is_chain && (f_len_bad || f_wraps);
    wire good_chain  = f_is_chain && !bad_type && !bad_nest && !bad_len;
    wire good_item   = !f_is_chain && !bad_type;
    wire seg_end     = remain == 28'h000_0001;
    wire desc_err    = take_desc && (bad_type || bad_nest || bad_len);
    wire err_any     = desc_err || (take_start && start_bad);

    sgl_desc_pkg::err_code_t len_code;
    sgl_desc_pkg::err_code_t start_code;
    sgl_desc_pkg::err_code_t desc_code;
    sgl_desc_pkg::err_code_t next_code;

    assign len_code   = meta ? sgl_desc_pkg::err_meta_len
                             : sgl_desc_pkg::err_data_len;
    assign start_code = list_meta ? sgl_desc_pkg::err_meta_len
                                  : sgl_desc_pkg::err_data_len;
    assign desc_code  = bad_type ? sgl_desc_pkg::err_type
                      : bad_nest ? sgl_desc_pkg::err_nesting
                      : len_code;
    assign next_code  = take_start ? start_code : desc_code;

    assign desc_ready = in_walk && !item_valid;
    assign busy       = in_walk || in_fetch;

    // Walker next state
    always_comb begin
        next_state = state;
        case (state)
            sgl_desc_pkg::st_idle,
            sgl_desc_pkg::st_halt: begin
                if (take_start) begin
                    next_state = start_bad ? sgl_desc_pkg::st_halt
                                           : sgl_desc_pkg::st_walk;
                end
            end
            sgl_desc_pkg::st_walk: begin
                if (take_desc) begin
                    if (bad_type || bad_nest || bad_len) begin
                        next_state = sgl_desc_pkg::st_halt;
                    end else if (good_chain) begin
                        next_state = sgl_desc_pkg::st_fetch;
                    end else if (seg_end) begin
                        next_state = sgl_desc_pkg::st_idle;
                    end
                end
            end
            sgl_desc_pkg::st_fetch: begin
                if (fetch_take) begin
                    next_state = sgl_desc_pkg::st_walk;
                end
            end
            default: begin
                next_state = sgl_desc_pkg::st_idle;
            end
        endcase
    end

    // Segment bookkeeping next values
    always_comb begin
        next_remain   = remain;
        next_seg_last = seg_last;
        next_meta     = meta;
        if (take_start) begin
            next_remain   = list_len[31:`SGL_GRAIN_SHIFT];
            next_seg_last = list_last;
            next_meta     = list_meta;
        end else if (fetch_take) begin
            next_remain   = fetch_len[31:`SGL_GRAIN_SHIFT];
            next_seg_last = fetch_last;
        end else if (take_desc && good_item) begin
            next_remain   = remain - 28'h000_0001;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= sgl_desc_pkg::st_idle;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            remain   <= 28'h000_0000;
            seg_last <= 1'b0;
            meta     <= 1'b0;
        end else begin
            remain   <= next_remain;
            seg_last <= next_seg_last;
            meta     <= next_meta;
        end
    end

    // Fetch request, held until taken
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fetch_valid <= 1'b0;
        end else if (take_desc && good_chain) begin
            fetch_valid <= 1'b1;
        end else if (fetch_take) begin
            fetch_valid <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fetch_addr <= 64'h0000_0000_0000_0000;
            fetch_len  <= 32'h0000_0000;
            fetch_last <= 1'b0;
        end else if (take_desc && good_chain) begin
            fetch_addr <= f_addr;
            fetch_len  <= f_len;
            fetch_last <= f_kind == `SGL_TYPE_LAST;
        end
    end

    // Data and bucket items, held until taken
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            item_valid <= 1'b0;
        end else if (take_desc && good_item) begin
            item_valid <= 1'b1;
        end else if (item_take) begin
            item_valid <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            item_kind <= 4'h0;
            item_addr <= 64'h0000_0000_0000_0000;
            item_len  <= 32'h0000_0000;
        end else if (take_desc && good_item) begin
            item_kind <= f_kind;
            item_addr <= f_addr;
            item_len  <= f_len;
        end
    end

    // Error report, one-cycle pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            err_valid <= 1'b0;
        end else begin
            err_valid <= err_any;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            err_code <= 3'h0;
        end else if (err_any) begin
            err_code <= next_code;
        end
    end

    // List finished after the last entry of a segment
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            list_done <= 1'b0;
        end else begin
            list_done <= take_desc && good_item && seg_end;
        end
    end

endmodule

/* bench/sgl_chk.sv */
// Purpose: Port checks of the descriptor checker
// Assumes: One clock, asynchronous high reset
// Notes:   Bound to the top module
`timescale 1ns/100ps
module sgl_chk (
    input wire logic         mclk, sys_rst, list_start, list_meta, list_last,
    input wire logic [31:0]  list_len,
    input wire logic         desc_valid, desc_ready, item_valid, fetch_valid, fetch_ready,
    input wire logic [127:0] desc_data,
    input wire logic [3:0]   item_kind,
    input wire logic [63:0]  fetch_addr,
    input wire logic [31:0]  fetch_len,
    input wire logic         fetch_last, err_valid, busy,
    input wire logic [2:0]   err_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic in_last;
    logic meta;
    wire take = desc_valid && desc_ready;
    wire [3:0] typ = desc_data[127:124];
    wire ok0 = desc_data[123:120] == 4'h0;
    wire seg = ok0 && (typ == 4'h2 || typ == 4'h3);
    wire [64:0] sum = {1'b0, desc_data[63:0]} + {33'h0, desc_data[95:64]};
    wire lbad = desc_data[95:64] == 32'h0 || desc_data[67:64] != 4'h0
                || sum > 65'h1_0000_0000_0000_0000;
    // Segment in walk is last; list kind
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            in_last <= 1'b0;
            meta <= 1'b0;
        end else if (list_start && !busy) begin
            in_last <= list_last;
            meta <= list_meta;
        end else if (fetch_valid && fetch_ready) begin
            in_last <= fetch_last;
        end
    end
    wire lbad_s = list_len == 32'h0 || list_len[3:0] != 4'h0;
    a_start_len: assert property (list_start && !busy && lbad_s |=> err_valid
        && err_code == (meta ? 3'h3 : 3'h2)) else $error("bad start length not flagged");
    a_type_err: assert property (take && (!ok0 || typ > 4'h3) |=> err_valid
        && err_code == 3'h1) else $error("type error not flagged");
    a_nest_err: assert property (take && seg && in_last |=> err_valid && err_code == 3'h4)
        else $error("nested segment not flagged");
    a_wrap_err: assert property (take && seg && !in_last && lbad |=> err_valid
        && err_code == (meta ? 3'h3 : 3'h2)) else $error("length error not flagged");
    a_seg_fetch: assert property (take && seg && !in_last && !lbad |=> fetch_valid
        && fetch_addr == $past(desc_data[63:0]) && fetch_len == $past(desc_data[95:64])
        && fetch_last == $past(desc_data[124])) else $error("fetch fields wrong");
    a_item_kind: assert property (take && ok0 && typ < 4'h2 |=> item_valid
        && item_kind == $past(desc_data[127:124])) else $error("item kind wrong");
    a_fetch_hold: assert property (fetch_valid && !fetch_ready |=> fetch_valid
        && $stable(fetch_addr) && $stable(fetch_len)) else $error("fetch not held");
    a_last_nofetch: assert property (in_last |-> !fetch_valid)
        else $error("fetch from last segment");
    c_chain: cover property (fetch_valid && fetch_ready && !fetch_last);
    c_final: cover property (fetch_valid && fetch_ready && fetch_last);
    c_nest: cover property (err_valid && err_code == 3'h4);
endmodule

bind sgl_segment_descriptor_check sgl_chk i_chk (.mclk, .sys_rst, .list_start, .list_meta,
    .list_last, .list_len, .desc_valid, .desc_ready, .item_valid, .fetch_valid, .fetch_ready,
    .desc_data, .item_kind, .fetch_addr, .fetch_len, .fetch_last, .err_valid, .busy, .err_code);

/* bench/sgl_host_mem.sv */
// Purpose: Host memory serving list descriptors and taking fetches
// Assumes: Bench fills mem and n while the walker is idle; ptr rewinds at list start
// Notes:   Fetch taken after stall cycles
`timescale 1ns/100ps
module sgl_host_mem (
    input  wire logic    mclk,
    input  wire logic    sys_rst,
    input  wire logic    list_start,
    input  wire logic    desc_ready,
    input  wire logic    fetch_valid,
    output logic         desc_valid,
    output logic [127:0] desc_data,
    output logic         fetch_ready
);
    logic [127:0] mem [0:7] = '{default: '0};
    int n = 0;
    int ptr = 0;
    int stall = 0;
    int cnt;
    assign desc_valid = ptr < n;
    // Idle lines show a pattern, not the last entry
    assign desc_data = desc_valid ? mem[ptr[2:0]] : ~mem[0];
    assign fetch_ready = fetch_valid && cnt >= stall;
    always @(posedge mclk) begin
        if (list_start)
            ptr <= 0;
        else if (desc_valid && desc_ready)
            ptr <= ptr + 1;
    end
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            cnt <= 0;
        else
            cnt <= (fetch_valid && !fetch_ready) ? cnt + 1 : 0;
    end
endmodule

/* bench/testbench.sv */
// Purpose: Directed scenarios for the descriptor checker
// Assumes: Host memory model feeds descriptors; items always taken
// Notes:   Events compare as done, err, fetch, item flags
`timescale 1ns/100ps
module testbench;
    logic mclk = 1'b0, sys_rst = 1'b1, list_start = 1'b0, list_meta = 1'b0, list_last = 1'b0;
    logic [31:0] list_len = 32'h0;
    logic item_ready = 1'b1;
    logic desc_valid, desc_ready, item_valid, fetch_valid, fetch_ready, fetch_last;
    logic err_valid, list_done, busy;
    logic [127:0] desc_data;
    logic [3:0] item_kind;
    logic [63:0] item_addr, fetch_addr;
    logic [31:0] item_len, fetch_len;
    logic [2:0] err_code;
    int n_fail = 0;
    int n_compared = 0;
    sgl_segment_descriptor_check i_dut (.mclk, .sys_rst, .list_start, .list_meta, .list_len,
        .list_last, .desc_valid, .desc_ready, .desc_data, .item_valid, .item_ready, .item_kind,
        .item_addr, .item_len, .fetch_valid, .fetch_ready, .fetch_addr, .fetch_len, .fetch_last,
        .err_valid, .err_code, .list_done, .busy);
    sgl_host_mem i_mem (.mclk, .sys_rst, .list_start, .desc_ready, .fetch_valid, .desc_valid,
        .desc_data, .fetch_ready);
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic results;
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bytes 14..12 carry junk
    function automatic logic [127:0] d(input logic [7:0] id, input logic [63:0] a,
                                       input logic [31:0] l);
        return {id, 24'h5ac396, l, a};
    endfunction
    task automatic put(input int k, input logic [127:0] v);
        i_mem.mem[k] = v;
        i_mem.n = k + 1;
    endtask
    task automatic start(input logic meta, input logic last, input logic [31:0] len);
        @(posedge mclk);
        list_meta <= meta;
        list_last <= last;
        list_len <= len;
        list_start <= 1'b1;
        @(posedge mclk);
        list_start <= 1'b0;
    endtask
    task automatic step(input logic [3:0] ev, input logic [63:0] a, input logic [31:0] l,
                        input logic [3:0] x);
        int i;
        logic [3:0] seen;
        for (i = 0; i < 60; i++) begin
            #1;
            seen = {list_done, err_valid, fetch_valid, item_valid};
            if (seen != 4'h0)
                break;
            @(posedge mclk);
        end
        if (i == 60) begin
            n_fail++;
            results();
        end
        chk(seen, ev);
        if (ev[0]) begin
            chk(item_addr, a);
            chk(item_len, l);
            chk(item_kind, x);
        end
        if (ev[1]) begin
            chk(fetch_addr, a);
            chk(fetch_len, l);
            chk(fetch_last, x);
            chk({busy, desc_ready}, 2'h2);
        end
        if (ev[2])
            chk(err_code, x);
        if (ev[2] || ev[3])
            chk({busy, desc_ready}, 2'h0);
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            #1;
            if (fetch_valid !== 1'b1)
                break;
        end
        if (i == 20) begin
            n_fail++;
            results();
        end
    endtask
    task automatic t_start_len;
        start(1'b0, 1'b0, 32'h0);
        step(4'h4, 64'h0, 32'h0, 4'h2);
        start(1'b1, 1'b0, 32'h18);
        step(4'h4, 64'h0, 32'h0, 4'h3);
    endtask
    task automatic t_walk;
        i_mem.stall = 3;
        put(0, d(8'h00, 64'h100, 32'h200));
        put(1, d(8'h20, 64'h1000, 32'h20));
        put(2, d(8'h10, 64'h0, 32'h40));
        put(3, d(8'h30, 64'hffff_ffff_ffff_fff0, 32'h10));
        put(4, d(8'h00, 64'h8, 32'h10));
        start(1'b0, 1'b0, 32'h20);
        step(4'h1, 64'h100, 32'h200, 4'h0);
        step(4'h2, 64'h1000, 32'h20, 4'h0);
        step(4'h1, 64'h0, 32'h40, 4'h1);
        step(4'h2, 64'hffff_ffff_ffff_fff0, 32'h10, 4'h1);
        step(4'h9, 64'h8, 32'h10, 4'h0);
    endtask
    task automatic t_err(input logic meta, input logic last, input logic [7:0] id,
                         input logic [63:0] a, input logic [31:0] l, input logic [3:0] code);
        put(0, d(id, a, l));
        start(meta, last, 32'h10);
        step(4'h4, 64'h0, 32'h0, code);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        t_start_len();
        t_walk();
        t_err(1'b0, 1'b1, 8'h20, 64'h40, 32'h10, 4'h4);
        t_err(1'b0, 1'b1, 8'h30, 64'h40, 32'h10, 4'h4);
        t_err(1'b0, 1'b0, 8'h21, 64'h40, 32'h10, 4'h1);
        t_err(1'b1, 1'b0, 8'h50, 64'h40, 32'h10, 4'h1);
        t_err(1'b0, 1'b0, 8'h20, 64'hffff_ffff_ffff_fff0, 32'h20, 4'h2);
        t_err(1'b1, 1'b0, 8'h30, 64'hffff_ffff_ffff_fff0, 32'h20, 4'h3);
        t_err(1'b1, 1'b0, 8'h20, 64'h40, 32'h18, 4'h3);
        t_err(1'b0, 1'b0, 8'h30, 64'h40, 32'h0, 4'h2);
        results();
    end
    initial begin
        #100000;
        n_fail++;
        results();
    end
endmodule
